// ### hdl/flltsa_regs.sv
`timescale 1ns/10ps
`default_nettype none

module flltsa_regs
  import flltsa_pkg::*;
#(
  parameter bit          TS_PRESENT   = 1'b1,              // Time stamping built in
  parameter logic [15:0] TS_LAT_RESET = TS_LAT_RESET_DEF   // Build-dependent latency
)(
  input  wire logic            clk_in,             // System clock, 125 MHz
  input  wire logic            sys_rst_in,         // Async reset, active high
  input  wire logic            hsel_in,            // AHB slave select
  input  wire logic [31:0]     haddr_in,           // AHB address
  input  wire logic [1:0]      htrans_in,          // AHB transfer type
  input  wire logic            hwrite_in,          // AHB write
  input  wire logic [2:0]      hsize_in,           // AHB size, word only
  input  wire logic            hready_in,          // AHB bus ready
  input  wire logic [31:0]     hwdata_in,          // AHB write data
  output logic [31:0]          hrdata_out,         // AHB read data
  output logic                 hreadyout_out,      // AHB slave ready
  output logic                 hresp_out,          // AHB response
  input  wire logic [14:0]     rx_default_max_in,  // Receive limit from other settings
  input  wire logic [14:0]     tx_default_max_in,  // Transmit limit from other settings
  input  wire logic [TS_W-1:0] tx_ts_in,           // Raw transmit timestamp
  input  wire logic            tx_ts_valid_in,     // Raw timestamp strobe
  output logic [14:0]          rx_max_len_out,     // Largest received frame
  output logic [14:0]          tx_max_len_out,     // Largest transmitted frame
  output logic [TS_W-1:0]      tx_ts_out,          // Corrected timestamp
  output logic                 tx_ts_valid_out     // Corrected timestamp strobe
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  localparam flltsa_state_type ST_RESET = '{
    post_rst: 1'b1,
    wr_pend:  1'b0,
    wr_code:  CODE_NONE,
    rx_en:    RX_EN_RESET,
    rx_size:  SIZE_RESET,
    tx_en:    TX_EN_RESET,
    tx_size:  SIZE_RESET,
    ts_en:    TS_EN_RESET,
    ts_lat:   TS_LAT_RESET,
    rdata:    32'h0
  };

  flltsa_state_type st_ff;
  flltsa_state_type nxt_st;

  logic       take;
  logic [1:0] code;

  flltsa_cfg_if cfg ();

  function automatic logic [31:0] read_word(input logic [1:0] c, input flltsa_state_type s);
    logic [31:0] w;
    w = 32'h0;
    unique case (c)
      CODE_RX: begin
        w = flltsa_pack_limit(s.rx_en, s.rx_size);
      end
      CODE_TX: begin
        w = flltsa_pack_limit(s.tx_en, s.tx_size);
      end
      CODE_TS: begin
        if (TS_PRESENT) begin
          w = {15'h0, s.ts_en, s.ts_lat};
        end
      end
      CODE_NONE: begin
        w = 32'h0;
      end
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave and register file

  assign take = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);
  assign code = flltsa_decode(haddr_in);

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.post_rst = 1'b0;
    if (st_ff.wr_pend) begin
      unique case (st_ff.wr_code)
        CODE_RX: begin
          nxt_st.rx_en   = hwdata_in[ENABLE_BIT];
          nxt_st.rx_size = hwdata_in[SIZE_MSB:0];
        end
        CODE_TX: begin
          nxt_st.tx_en   = hwdata_in[ENABLE_BIT];
          nxt_st.tx_size = hwdata_in[SIZE_MSB:0];
        end
        CODE_TS: begin
          if (TS_PRESENT) begin
            nxt_st.ts_en  = hwdata_in[ENABLE_BIT];
            nxt_st.ts_lat = hwdata_in[LAT_MSB:0];
          end
        end
        CODE_NONE: begin
          nxt_st.ts_en = st_ff.ts_en;
        end
      endcase
    end
    nxt_st.wr_pend = take && hwrite_in;
    nxt_st.wr_code = code;
    if (take && !hwrite_in) begin
      nxt_st.rdata = read_word(code, nxt_st);
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata_out    = st_ff.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = HRESP_OKAY;

  ////////////////////////////////////////////////////////////////////////////////
  // Applied limits and timestamp correction

  assign cfg.rx_en   = st_ff.rx_en;
  assign cfg.rx_size = st_ff.rx_size;
  assign cfg.tx_en   = st_ff.tx_en;
  assign cfg.tx_size = st_ff.tx_size;
  assign cfg.ts_en   = TS_PRESENT ? st_ff.ts_en : 1'b0;
  assign cfg.ts_lat  = st_ff.ts_lat;

  flltsa_apply flltsa_apply_inst (
    .clk_in            (clk_in),
    .sys_rst_in        (sys_rst_in),
    .cfg_in            (cfg),
    .rx_default_max_in (rx_default_max_in),
    .tx_default_max_in (tx_default_max_in),
    .tx_ts_in          (tx_ts_in),
    .tx_ts_valid_in    (tx_ts_valid_in),
    .rx_max_len_out    (rx_max_len_out),
    .tx_max_len_out    (tx_max_len_out),
    .tx_ts_out         (tx_ts_out),
    .tx_ts_valid_out   (tx_ts_valid_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_addr(logic [1:0] c, logic wr);
    take && (hwrite_in == wr) && (code == c);
  endsequence

  sequence s_write(logic [1:0] c);
    s_addr(c, 1'b1) ##1 1'b1;
  endsequence

  property p_rx_store;
    @(posedge clk_in) disable iff (sys_rst_in)
      s_write(CODE_RX) |=> st_ff.rx_size == $past(hwdata_in[14:0]) &&
                           st_ff.rx_en == $past(hwdata_in[16]);
  endproperty
  a_rx_store: assert property (p_rx_store)
    else $error("receive size not stored as written");

  property p_tx_store;
    @(posedge clk_in) disable iff (sys_rst_in)
      s_write(CODE_TX) |=> st_ff.tx_size == $past(hwdata_in[14:0]) &&
                           st_ff.tx_en == $past(hwdata_in[16]);
  endproperty
  a_tx_store: assert property (p_tx_store)
    else $error("transmit size not stored as written");

  property p_tx_reset;
    @(posedge clk_in) disable iff (sys_rst_in)
      st_ff.post_rst |-> st_ff.tx_size == 15'h05EE && !st_ff.tx_en && !st_ff.rx_en;
  endproperty
  a_tx_reset: assert property (p_tx_reset)
    else $error("limit registers left reset wrong");

  property p_lat_store;
    @(posedge clk_in) disable iff (sys_rst_in)
      (TS_PRESENT and s_write(CODE_TS)) |=> st_ff.ts_lat == $past(hwdata_in[15:0]);
  endproperty
  a_lat_store: assert property (p_lat_store)
    else $error("latency value not stored as written");

  property p_ts_en_reset;
    @(posedge clk_in) disable iff (sys_rst_in)
      st_ff.post_rst |-> st_ff.ts_en;
  endproperty
  a_ts_en_reset: assert property (p_ts_en_reset)
    else $error("correction enable did not reset to one");

  property p_lat_reset;
    @(posedge clk_in) disable iff (sys_rst_in)
      st_ff.post_rst |-> st_ff.ts_lat == TS_LAT_RESET;
  endproperty
  a_lat_reset: assert property (p_lat_reset)
    else $error("latency field reset value wrong");

  property p_ts_absent;
    @(posedge clk_in) disable iff (sys_rst_in)
      (!TS_PRESENT and s_addr(CODE_TS, 1'b0)) |=> hrdata_out == 32'h0;
  endproperty
  a_ts_absent: assert property (p_ts_absent)
    else $error("absent adjustment register returned data");

  property p_read_back;
    @(posedge clk_in) disable iff (sys_rst_in)
      s_addr(CODE_RX, 1'b0) |=> hrdata_out == {15'h0, st_ff.rx_en, 1'b0, st_ff.rx_size};
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("receive limit read back wrong");

  property p_reserved_zero;
    @(posedge clk_in) disable iff (sys_rst_in)
      $changed(hrdata_out) |-> hrdata_out[31:17] == 15'h0 &&
        ($past(code) == CODE_TS || !hrdata_out[15]);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_none_zero;
    @(posedge clk_in) disable iff (sys_rst_in)
      s_addr(CODE_NONE, 1'b0) |=> hrdata_out == 32'h0;
  endproperty
  a_none_zero: assert property (p_none_zero)
    else $error("unmapped read returned data");

  property p_tx_read_back;
    @(posedge clk_in) disable iff (sys_rst_in)
      s_addr(CODE_TX, 1'b0) |=> hrdata_out == {15'h0, st_ff.tx_en, 1'b0, st_ff.tx_size};
  endproperty
  a_tx_read_back: assert property (p_tx_read_back)
    else $error("transmit limit read back wrong");

  property p_ts_read_back;
    @(posedge clk_in) disable iff (sys_rst_in)
      (TS_PRESENT and s_addr(CODE_TS, 1'b0)) |=>
        hrdata_out == {15'h0, st_ff.ts_en, st_ff.ts_lat};
  endproperty
  a_ts_read_back: assert property (p_ts_read_back)
    else $error("adjustment register read back wrong");

  property p_ts_en_store;
    @(posedge clk_in) disable iff (sys_rst_in)
      (TS_PRESENT and s_write(CODE_TS)) |=> st_ff.ts_en == $past(hwdata_in[16]);
  endproperty
  a_ts_en_store: assert property (p_ts_en_store)
    else $error("correction enable not stored as written");

  property p_rx_reset;
    @(posedge clk_in) disable iff (sys_rst_in)
      st_ff.post_rst |-> st_ff.rx_size == SIZE_RESET;
  endproperty
  a_rx_reset: assert property (p_rx_reset)
    else $error("receive size reset value wrong");

  // Write to the receive limit register leaves the others alone
  property p_rx_write_only;
    @(posedge clk_in) disable iff (sys_rst_in)
      s_write(CODE_RX) |=> $stable(st_ff.tx_size) && $stable(st_ff.tx_en) &&
                           $stable(st_ff.ts_lat) && $stable(st_ff.ts_en);
  endproperty
  a_rx_write_only: assert property (p_rx_write_only)
    else $error("receive limit write disturbed other registers");

  property p_none_write;
    @(posedge clk_in) disable iff (sys_rst_in)
      s_write(CODE_NONE) |=> $stable(st_ff.rx_size) && $stable(st_ff.tx_size) &&
                             $stable(st_ff.rx_en) && $stable(st_ff.tx_en) &&
                             $stable(st_ff.ts_lat) && $stable(st_ff.ts_en);
  endproperty
  a_none_write: assert property (p_none_write)
    else $error("unmapped write changed a register");

  property p_ts_absent_write;
    @(posedge clk_in) disable iff (sys_rst_in)
      (!TS_PRESENT and s_write(CODE_TS)) |=> $stable(st_ff.ts_lat) && $stable(st_ff.ts_en);
  endproperty
  a_ts_absent_write: assert property (p_ts_absent_write)
    else $error("absent adjustment register took a write");

  // Read data stands until the next read is taken
  property p_rd_hold;
    @(posedge clk_in) disable iff (sys_rst_in)
      !(take && !hwrite_in) |=> $stable(hrdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");

endmodule

`default_nettype wire

// ### hdl/flltsa_pkg.sv
package flltsa_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map

  localparam logic [11:0] RX_LIMIT_OFS  = 12'h000;
  localparam logic [11:0] TX_LIMIT_OFS  = 12'h004;
  localparam logic [11:0] TS_ADJUST_OFS = 12'h008;

  localparam logic [1:0] CODE_RX   = 2'h0;
  localparam logic [1:0] CODE_TX   = 2'h1;
  localparam logic [1:0] CODE_TS   = 2'h2;
  localparam logic [1:0] CODE_NONE = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Field layout and reset values

  localparam int SIZE_MSB   = 14;
  localparam int LAT_MSB    = 15;
  localparam int ENABLE_BIT = 16;

  localparam logic [14:0] SIZE_RESET    = 15'h05EE;
  localparam logic [14:0] SIZE_LEGAL_MIN = 15'h05EE;
  localparam logic        RX_EN_RESET   = 1'b0;
  localparam logic        TX_EN_RESET   = 1'b0;
  localparam logic        TS_EN_RESET   = 1'b1;
  localparam logic [15:0] TS_LAT_RESET_DEF = 16'h0000;

  localparam int TS_W = 64;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus encodings

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // State types

  typedef struct packed {
    logic        post_rst;
    logic        wr_pend;
    logic [1:0]  wr_code;
    logic        rx_en;
    logic [14:0] rx_size;
    logic        tx_en;
    logic [14:0] tx_size;
    logic        ts_en;
    logic [15:0] ts_lat;
    logic [31:0] rdata;
  } flltsa_state_type;

  typedef struct packed {
    logic [14:0]     rx_max;
    logic [14:0]     tx_max;
    logic [TS_W-1:0] ts;
    logic            ts_valid;
  } flltsa_apply_state_type;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [1:0] flltsa_decode(input logic [31:0] addr);
    logic [1:0] code;
    code = CODE_NONE;
    if (addr[31:12] == 20'h0) begin
      if (addr[11:0] == RX_LIMIT_OFS) begin
        code = CODE_RX;
      end else if (addr[11:0] == TX_LIMIT_OFS) begin
        code = CODE_TX;
      end else if (addr[11:0] == TS_ADJUST_OFS) begin
        code = CODE_TS;
      end
    end
    return code;
  endfunction

  function automatic logic [31:0] flltsa_pack_limit(input logic en, input logic [14:0] size);
    return {15'h0, en, 1'b0, size};
  endfunction

endpackage

// ### hdl/flltsa_cfg_if.sv
`timescale 1ns/10ps
`default_nettype none

interface flltsa_cfg_if;
  logic        rx_en;
  logic [14:0] rx_size;
  logic        tx_en;
  logic [14:0] tx_size;
  logic        ts_en;
  logic [15:0] ts_lat;

  modport src (output rx_en, rx_size, tx_en, tx_size, ts_en, ts_lat);
  modport dst (input rx_en, rx_size, tx_en, tx_size, ts_en, ts_lat);
endinterface

`default_nettype wire

// ### hdl/flltsa_apply.sv
`timescale 1ns/10ps
`default_nettype none

module flltsa_apply
  import flltsa_pkg::*;
(
  input  wire logic            clk_in,               // System clock
  input  wire logic            sys_rst_in,           // Async reset, active high
  flltsa_cfg_if.dst            cfg_in,               // Register contents
  input  wire logic [14:0]     rx_default_max_in,    // Receive limit from other settings
  input  wire logic [14:0]     tx_default_max_in,    // Transmit limit from other settings
  input  wire logic [TS_W-1:0] tx_ts_in,             // Raw transmit timestamp, ns
  input  wire logic            tx_ts_valid_in,       // Raw timestamp strobe
  output logic [14:0]          rx_max_len_out,       // Largest received frame
  output logic [14:0]          tx_max_len_out,       // Largest transmitted frame
  output logic [TS_W-1:0]      tx_ts_out,            // Corrected timestamp
  output logic                 tx_ts_valid_out       // Corrected timestamp strobe
);

  flltsa_apply_state_type st_ff;
  flltsa_apply_state_type nxt_st;

  localparam flltsa_apply_state_type ST_RESET = '{
    rx_max:   SIZE_RESET,
    tx_max:   SIZE_RESET,
    ts:       '0,
    ts_valid: 1'b0
  };

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.rx_max   = cfg_in.rx_en ? cfg_in.rx_size : rx_default_max_in;
    nxt_st.tx_max   = cfg_in.tx_en ? cfg_in.tx_size : tx_default_max_in;
    nxt_st.ts_valid = tx_ts_valid_in;
    if (tx_ts_valid_in) begin
      nxt_st.ts = cfg_in.ts_en ? tx_ts_in + {{(TS_W-16){1'b0}}, cfg_in.ts_lat}
                               : tx_ts_in;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rx_max_len_out  = st_ff.rx_max;
  assign tx_max_len_out  = st_ff.tx_max;
  assign tx_ts_out       = st_ff.ts;
  assign tx_ts_valid_out = st_ff.ts_valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_rx_limit_select;
    @(posedge clk_in) disable iff (sys_rst_in)
      1'b1 |=> rx_max_len_out == ($past(cfg_in.rx_en) ? $past(cfg_in.rx_size)
                                                       : $past(rx_default_max_in));
  endproperty
  a_rx_limit_select: assert property (p_rx_limit_select)
    else $error("receive limit not chosen by enable");

  property p_tx_limit_select;
    @(posedge clk_in) disable iff (sys_rst_in)
      1'b1 |=> tx_max_len_out == ($past(cfg_in.tx_en) ? $past(cfg_in.tx_size)
                                                       : $past(tx_default_max_in));
  endproperty
  a_tx_limit_select: assert property (p_tx_limit_select)
    else $error("transmit limit not chosen by enable");

  property p_ts_correct;
    @(posedge clk_in) disable iff (sys_rst_in)
      tx_ts_valid_in |=> tx_ts_valid_out &&
        (tx_ts_out == ($past(cfg_in.ts_en)
                       ? $past(tx_ts_in) + {{(TS_W-16){1'b0}}, $past(cfg_in.ts_lat)}
                       : $past(tx_ts_in)));
  endproperty
  a_ts_correct: assert property (p_ts_correct)
    else $error("transmit timestamp correction wrong");

endmodule

`default_nettype wire

// ### bench/flltsa_regs_test.sv
`timescale 1ns/10ps
`default_nettype none

module flltsa_regs_test
  import flltsa_pkg::*;
;
  localparam logic [15:0] LAT_RST = 16'h01A5;

  logic            clk_in            = 1'b0;
  logic            sys_rst_in        = 1'b1;
  logic            hsel_in           = 1'b0;
  logic [31:0]     haddr_in          = 32'h0;
  logic [1:0]      htrans_in         = 2'h0;
  logic            hwrite_in         = 1'b0;
  logic [31:0]     hwdata_in         = 32'h0;
  logic [31:0]     hrdata_out;
  logic            hreadyout_out;
  logic            hresp_out;
  logic [14:0]     rx_default_max_in = 15'h0100;
  logic [14:0]     tx_default_max_in = 15'h0200;
  logic [TS_W-1:0] tx_ts_in          = '0;
  logic            tx_ts_valid_in    = 1'b0;
  logic [14:0]     rx_max_len_out;
  logic [14:0]     tx_max_len_out;
  logic [TS_W-1:0] tx_ts_out;
  logic            tx_ts_valid_out;
  int              n_errors          = 0;
  int              n_tests           = 0;
  logic [31:0]     rd_q[$];
  logic [TS_W-1:0] ts_q[$];
  logic            rd_dp             = 1'b0;
  logic [14:0]     exp_rx;
  logic [14:0]     exp_tx;

  always #4 clk_in = ~clk_in;

  flltsa_regs #(
    .TS_PRESENT   (1'b1),
    .TS_LAT_RESET (LAT_RST)
  ) flltsa_regs_inst (
    .clk_in            (clk_in),
    .sys_rst_in        (sys_rst_in),
    .hsel_in           (hsel_in),
    .haddr_in          (haddr_in),
    .htrans_in         (htrans_in),
    .hwrite_in         (hwrite_in),
    .hsize_in          (3'h2),
    .hready_in         (hreadyout_out),
    .hwdata_in         (hwdata_in),
    .hrdata_out        (hrdata_out),
    .hreadyout_out     (hreadyout_out),
    .hresp_out         (hresp_out),
    .rx_default_max_in (rx_default_max_in),
    .tx_default_max_in (tx_default_max_in),
    .tx_ts_in          (tx_ts_in),
    .tx_ts_valid_in    (tx_ts_valid_in),
    .rx_max_len_out    (rx_max_len_out),
    .tx_max_len_out    (tx_max_len_out),
    .tx_ts_out         (tx_ts_out),
    .tx_ts_valid_out   (tx_ts_valid_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    @(posedge clk_in);
    hsel_in   <= 1'b1;
    htrans_in <= HTRANS_NONSEQ;
    haddr_in  <= addr;
    hwrite_in <= wr;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    hsel_in   <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= data;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
  endtask

  task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, addr, $urandom);
  endtask

  task automatic stamp(input logic [TS_W-1:0] v, input logic [TS_W-1:0] exp);
    @(posedge clk_in);
    ts_q.push_back(exp);
    tx_ts_valid_in <= 1'b1;
    tx_ts_in       <= v;
    @(posedge clk_in);
    tx_ts_valid_in <= 1'b0;
  endtask

  task automatic lim;
    repeat (3) @(posedge clk_in);
    #1;
    check("rx limit", 64'(exp_rx), 64'(rx_max_len_out));
    check("tx limit", 64'(exp_tx), 64'(tx_max_len_out));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Result watcher

  always @(posedge clk_in) begin
    if (rd_dp && hreadyout_out === 1'b1) begin
      if (rd_q.size() > 0) begin
        check("read data", 64'(rd_q.pop_front()), 64'(hrdata_out));
        check("read response", 64'(HRESP_OKAY), 64'(hresp_out));
      end else begin
        check("unexpected read", 64'h0, 64'h1);
      end
    end
    if (hreadyout_out === 1'b1) begin
      rd_dp <= hsel_in && htrans_in == HTRANS_NONSEQ && !hwrite_in;
    end
    if (tx_ts_valid_out === 1'b1) begin
      if (ts_q.size() > 0) begin
        check("timestamp", ts_q.pop_front(), tx_ts_out);
      end else begin
        check("unexpected timestamp", 64'h0, 64'h1);
      end
    end
  end

  initial begin
    #100000;
    check("watchdog", 64'h0, 64'h1);
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Tests

  initial begin
    logic [31:0]     a;
    logic [31:0]     d;
    logic [15:0]     lat;
    logic [TS_W-1:0] v;
    void'($urandom(32'hCC341DBA));
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    exp_rx = rx_default_max_in;
    exp_tx = tx_default_max_in;
    rd(32'(RX_LIMIT_OFS), 32'h0000_05EE);
    rd(32'(TX_LIMIT_OFS), 32'h0000_05EE);
    rd(32'(TS_ADJUST_OFS), {15'h0, 1'b1, LAT_RST});
    rd(32'h0000_000C, 32'h0);
    lim();
    v = {$urandom, $urandom};
    stamp(v, v + 64'(LAT_RST));
    $display("Test reset done");

    for (int i = 0; i < 2; i++) begin
      a = (i == 0) ? 32'(RX_LIMIT_OFS) : 32'(TX_LIMIT_OFS);
      bus(1'b1, a, 32'hFFFF_FFFF);
      rd(a, 32'h0001_7FFF);
      if (i == 0) exp_rx = 15'h7FFF; else exp_tx = 15'h7FFF;
      lim();
      bus(1'b1, a, 32'h0001_05EE);
      rd(a, 32'h0001_05EE);
      if (i == 0) exp_rx = SIZE_LEGAL_MIN; else exp_tx = SIZE_LEGAL_MIN;
      lim();
      d = $urandom;
      d[16] = 1'b0;
      d[14:0] = 15'($urandom_range(32'h7FFF, 32'h05EE));
      bus(1'b1, a, d);
      rd(a, d & 32'h0000_7FFF);
      @(posedge clk_in);
      rx_default_max_in <= 15'($urandom);
      tx_default_max_in <= 15'($urandom);
      @(posedge clk_in);
      exp_rx = rx_default_max_in;
      exp_tx = tx_default_max_in;
      lim();
    end
    bus(1'b1, 32'h0000_1000, 32'hFFFF_FFFF);
    rd(32'(TX_LIMIT_OFS), d & 32'h0000_7FFF);
    $display("Test length limits done");

    lat = 16'($urandom);
    bus(1'b1, 32'(TS_ADJUST_OFS), {16'hFFFE, lat});
    rd(32'(TS_ADJUST_OFS), {16'h0000, lat});
    v = {$urandom, $urandom};
    stamp(v, v);
    bus(1'b1, 32'(TS_ADJUST_OFS), {16'h0001, lat});
    rd(32'(TS_ADJUST_OFS), {16'h0001, lat});
    v = 64'hFFFF_FFFF_FFFF_FFFF - 64'($urandom_range(3, 0));
    stamp(v, v + 64'(lat));
    v = {$urandom, $urandom};
    stamp(v, v + 64'(lat));
    $display("Test timestamp adjust done");

    repeat (4) @(posedge clk_in);
    check("pending reads", 64'h0, 64'(rd_q.size()));
    check("pending stamps", 64'h0, 64'(ts_q.size()));
    finish_test();
  end
endmodule

`default_nettype wire
